// file: hdl/fsp_defines.svh
// Register offsets, field positions, codes and sizes of the flash sequencer
`ifndef FSP_DEFINES_SVH
`define FSP_DEFINES_SVH
// Byte offsets of the registers
`define FSP_OFS_CTRL 8'h00
`define FSP_OFS_KEY 8'h04
`define FSP_OFS_ADRL 8'h08
`define FSP_OFS_ADRH 8'h0c
`define FSP_OFS_SRCL 8'h10
`define FSP_OFS_SRCH 8'h14
`define FSP_OFS_DAT0 8'h18
`define FSP_OFS_DAT1 8'h1c
// Control register fields
`define FSP_CTRL_LAUNCH 15
`define FSP_CTRL_WREN 14
`define FSP_CTRL_ERR 13
// Operation codes in control bits 3:0
`define FSP_OP_PAIR 4'h1
`define FSP_OP_ROW 4'h2
`define FSP_OP_PAGE 4'h3
// Unlock key values
`define FSP_KEY_FIRST 8'h55
`define FSP_KEY_SECOND 8'haa
// Array geometry; alignment bits in address units (two per instruction word)
`define FSP_ROW_WORDS 64
`define FSP_ROW_ALIGN_BITS 7
`define FSP_PAGE_ALIGN_BITS 10
`define FSP_BYTES_PER_WORD 3
// Reset value of every register
`define FSP_RST_ZERO 16'h0000
`endif

// file: hdl/fsp_pkg.sv
// Types shared by the flash sequencer modules
package fsp_pkg;
  // Sequencer states
  typedef enum logic [2:0] {
    FSP_IDLE,
    FSP_ERASE,
    FSP_FREQ,
    FSP_FCAP,
    FSP_PRD,
    FSP_PWR,
    FSP_DONE
  } fsp_state_t;
endpackage

// file: hdl/fsp_key_unlock.sv
// Two-write unlock key tracker guarding launches
`timescale 1ns/1ns
`include "fsp_defines.svh"
module fsp_key_unlock (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic wr_take,
  input wire logic wr_key,
  input wire logic [7:0] wr_byte,
  output logic armed
);
  // All state of the tracker
  typedef struct packed {
    logic first;
    logic armed;
  } fsp_key_t;
  fsp_key_t q, d;

  // Every accepted write moves the sequence; only 0x55 then 0xaa arms
  always_comb begin
    d = q;
    if (wr_take) begin
      d.first = wr_key && (wr_byte == `FSP_KEY_FIRST);
      d.armed = wr_key && q.first && (wr_byte == `FSP_KEY_SECOND);
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign armed = q.armed;
endmodule

// file: hdl/fsp_row_buf.sv
// Row buffer memory with registered read data
`timescale 1ns/1ns
module fsp_row_buf #(
  parameter int DEPTH = 64,
  parameter int WIDTH = 24
) (
  input wire logic mclk,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  // Memory words and read register as one state
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0] rd;
  } fsp_buf_t;
  fsp_buf_t q, d;

  // Write and read port
  always_comb begin
    d = q;
    d.rd = q.mem[raddr];
    if (we) begin
      d.mem[waddr] = wdata;
    end
  end

  // Contents need no reset
  always_ff @(posedge mclk) begin
    q <= d;
  end

  assign rdata = q.rd;
endmodule

// file: hdl/fsp_flash_seq.sv
// Run-time flash self-programming sequencer with Avalon-MM registers
//
// Overview of operation
// R1: Row is 64 instruction words, 192 bytes
// R2: Erase one page of eight rows
// R3: Pages 1536-byte aligned, rows 192-byte aligned
// R4: Core stalls while an operation runs
// R5: Launch bit 15 starts, self-clears when finished
// R6: Two-word program at every other word address
// R7: Row data fetched from RAM at source address
// R8: Software erases the page before programming
// R9: Write 0x55 then 0xaa before launching
// R10: Unlock key register is write-only
// R11: Target address is upper byte plus lower half
// R12: Control selects operation kind and holds launch
// R13: Software places two no-ops after launch
// R14: Launch without preceding key is ignored
`timescale 1ns/1ns
`include "fsp_defines.svh"
module fsp_flash_seq
  import fsp_pkg::*;
#(
  parameter int ROW_WORDS = `FSP_ROW_WORDS
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic cpu_stall,
  output logic flash_req,
  output logic flash_erase,
  output logic [23:0] flash_addr,
  output logic [23:0] flash_wdata,
  input wire logic flash_ack,
  output logic ram_rd,
  output logic [23:0] ram_addr,
  input wire logic [23:0] ram_rdata
);
  // Index width of the row buffer
  localparam int IW = $clog2(ROW_WORDS);

  // Refuse sizes the index and alignment cannot hold, while elaborating
  if (ROW_WORDS < 2 || ROW_WORDS > `FSP_ROW_WORDS ||
      (ROW_WORDS & (ROW_WORDS - 1)) != 0) begin : g_bad_rows
    $error("ROW_WORDS must be a power of two from 2 to 64");
  end

  // All state of the sequencer
  typedef struct packed {
    fsp_state_t st;
    logic [3:0] op;
    logic launch;
    logic wren;
    logic err;
    logic [15:0] adr_lo;
    logic [7:0] adr_hi;
    logic [15:0] src_lo;
    logic [7:0] src_hi;
    logic [23:0] dat0;
    logic [23:0] dat1;
    logic [6:0] idx;
    logic ack;
    logic [31:0] rdata;
    logic freq;
    logic ferase;
    logic [23:0] faddr;
    logic [23:0] fdata;
    logic rrd;
    logic [23:0] raddr;
  } fsp_regs_t;
  fsp_regs_t q, d;

  // Byte-enable mask for a register write
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // Merge written lanes into an old value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    return (old & ~be_mask(be)) | (wd & be_mask(be));
  endfunction

  // Byte address in RAM of one row word
  function automatic logic [23:0] src_of(input logic [23:0] base, input logic [6:0] i);
    return base + 24'(`FSP_BYTES_PER_WORD) * {17'h0, i};
  endfunction

  // Bus handshake terms
  logic bus_req;
  logic bus_go;
  logic wr_take;
  logic armed;
  logic [31:0] wmerged;
  logic [23:0] target;
  logic [23:0] source;
  logic [23:0] row_rdata;
  logic [23:0] row_base;
  logic [23:0] pair_base;
  logic last_word;

  assign bus_req = avs_read || avs_write;
  // Writes wait while an operation runs; reads always answer
  assign bus_go = bus_req && !q.ack && !(avs_write && q.launch); // R4
  assign wr_take = avs_write && q.ack;
  assign avs_waitrequest = bus_req && !q.ack;
  assign avs_readdata = q.rdata;
  // Full target and source addresses
  assign target = {q.adr_hi, q.adr_lo}; // R11
  assign source = {q.src_hi, q.src_lo};
  assign row_base = {target[23:`FSP_ROW_ALIGN_BITS], 7'h00}; // R3
  assign pair_base = {target[23:2], 2'b10}; // R6
  assign last_word = (q.op == `FSP_OP_PAIR) ? (q.idx == 7'd1) : (q.idx == 7'(ROW_WORDS - 1));

  // Unlock key tracker; any write other than the key pair disarms it
  fsp_key_unlock u_key (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .wr_take(wr_take),
    .wr_key(avs_address == `FSP_OFS_KEY),
    .wr_byte(avs_writedata[7:0]),
    .armed(armed)
  );

  // Row buffer filled from RAM, drained to the flash
  fsp_row_buf #(
    .DEPTH(ROW_WORDS),
    .WIDTH(24)
  ) u_buf (
    .mclk(mclk),
    .we(q.st == FSP_FCAP),
    .waddr(q.idx[IW-1:0]),
    .wdata(ram_rdata),
    .raddr(q.idx[IW-1:0]),
    .rdata(row_rdata)
  );

  // Next-state logic: bus slave, register writes and sequencer
  always_comb begin
    d = q;
    d.ack = bus_go;
    wmerged = '0;
    // Read data captured at the first cycle of a read
    if (bus_go && avs_read) begin
      case (avs_address)
        `FSP_OFS_CTRL: d.rdata = {16'h0, q.launch, q.wren, q.err, 9'h0, q.op};
        `FSP_OFS_ADRL: d.rdata = {16'h0, q.adr_lo};
        `FSP_OFS_ADRH: d.rdata = {24'h0, q.adr_hi};
        `FSP_OFS_SRCL: d.rdata = {16'h0, q.src_lo};
        `FSP_OFS_SRCH: d.rdata = {24'h0, q.src_hi};
        `FSP_OFS_DAT0: d.rdata = {8'h0, q.dat0};
        `FSP_OFS_DAT1: d.rdata = {8'h0, q.dat1};
        // Key register and unmapped offsets read zero
        default: d.rdata = '0; // R10
      endcase
    end
    // Register writes at the edge that ends the wait
    if (wr_take) begin
      case (avs_address)
        `FSP_OFS_CTRL: begin
          wmerged = merge({16'h0, q.launch, q.wren, q.err, 9'h0, q.op}, avs_writedata,
                          avs_byteenable);
          d.op = wmerged[3:0]; // R12
          d.wren = wmerged[`FSP_CTRL_WREN];
          d.err = wmerged[`FSP_CTRL_ERR];
          // Start only when enabled and the key pair came just before
          if (wmerged[`FSP_CTRL_LAUNCH] && wmerged[`FSP_CTRL_WREN] && armed) begin // R9 R14
            d.launch = 1'b1; // R5
            d.idx = '0;
            case (wmerged[3:0])
              `FSP_OP_PAGE: d.st = FSP_ERASE; // R2
              `FSP_OP_ROW: d.st = FSP_FREQ; // R7
              `FSP_OP_PAIR: d.st = FSP_PRD; // R6
              // Unknown operation flags an error and finishes
              default: begin
                d.err = 1'b1;
                d.st = FSP_DONE;
              end
            endcase
          end
        end
        `FSP_OFS_ADRL: begin
          wmerged = merge({16'h0, q.adr_lo}, avs_writedata, avs_byteenable);
          d.adr_lo = wmerged[15:0];
        end
        `FSP_OFS_ADRH: begin
          wmerged = merge({24'h0, q.adr_hi}, avs_writedata, avs_byteenable);
          d.adr_hi = wmerged[7:0];
        end
        `FSP_OFS_SRCL: begin
          wmerged = merge({16'h0, q.src_lo}, avs_writedata, avs_byteenable);
          d.src_lo = wmerged[15:0];
        end
        `FSP_OFS_SRCH: begin
          wmerged = merge({24'h0, q.src_hi}, avs_writedata, avs_byteenable);
          d.src_hi = wmerged[7:0];
        end
        `FSP_OFS_DAT0: begin
          wmerged = merge({8'h0, q.dat0}, avs_writedata, avs_byteenable);
          d.dat0 = wmerged[23:0];
        end
        `FSP_OFS_DAT1: begin
          wmerged = merge({8'h0, q.dat1}, avs_writedata, avs_byteenable);
          d.dat1 = wmerged[23:0];
        end
        // Key writes act only in the tracker; unmapped writes vanish
        default: wmerged = '0;
      endcase
    end
    // Sequencer
    d.rrd = 1'b0;
    case (q.st)
      // Waiting for a launch
      FSP_IDLE: begin
        d.freq = 1'b0;
      end
      // One erase request on the page boundary, held until acknowledged
      FSP_ERASE: begin
        d.freq = !(q.freq && flash_ack);
        d.ferase = 1'b1;
        d.faddr = {target[23:`FSP_PAGE_ALIGN_BITS], 10'h000}; // R3
        if (q.freq && flash_ack) begin
          d.st = FSP_DONE;
        end
      end
      // Ask RAM for the next source word
      FSP_FREQ: begin
        d.rrd = 1'b1;
        d.raddr = src_of(source, q.idx); // R7
        d.st = FSP_FCAP;
      end
      // RAM word arrives and is written into the buffer
      FSP_FCAP: begin
        if (q.idx == 7'(ROW_WORDS - 1)) begin // R1
          d.idx = '0;
          d.st = FSP_PRD;
        end else begin
          d.idx = q.idx + 7'd1;
          d.st = FSP_FREQ;
        end
      end
      // Buffer read settles before the word is presented
      FSP_PRD: begin
        d.st = FSP_PWR;
      end
      // Present one word to the flash until acknowledged
      FSP_PWR: begin
        d.freq = !(q.freq && flash_ack);
        d.ferase = 1'b0;
        if (q.op == `FSP_OP_PAIR) begin
          d.faddr = pair_base + {16'h0, q.idx, 1'b0}; // R6
          d.fdata = q.idx[0] ? q.dat1 : q.dat0;
        end else begin
          d.faddr = row_base + {16'h0, q.idx, 1'b0}; // R1 R3
          d.fdata = row_rdata;
        end
        if (q.freq && flash_ack) begin
          if (last_word) begin
            d.st = FSP_DONE;
          end else begin
            d.idx = q.idx + 7'd1;
            d.st = FSP_PRD;
          end
        end
      end
      // Release the core and clear the launch bit
      FSP_DONE: begin
        d.freq = 1'b0;
        d.launch = 1'b0; // R5
        d.st = FSP_IDLE;
      end
      default: d.st = FSP_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      q <= '0;
      q.st <= FSP_IDLE;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from flops
  assign cpu_stall = q.launch; // R4
  assign flash_req = q.freq;
  assign flash_erase = q.ferase;
  assign flash_addr = q.faddr;
  assign flash_wdata = q.fdata;
  assign ram_rd = q.rrd;
  assign ram_addr = q.raddr;

  // Launch bit only rises on a write that followed the key pair
  a_launch_keyed: assert property (@(posedge mclk) disable iff (sys_rst) // R14
    $rose(q.launch) |-> $past(armed) && $past(wr_take))
    else $error("launch without unlock");
  // Flash requests only while the core is stalled
  a_stall_cover: assert property (@(posedge mclk) disable iff (sys_rst) // R4
    flash_req |-> cpu_stall)
    else $error("flash busy without stall");
  // Erase addresses sit on page boundaries
  a_erase_align: assert property (@(posedge mclk) disable iff (sys_rst) // R2
    flash_req && flash_erase |-> flash_addr[9:0] == 10'h000)
    else $error("erase page misaligned");
  // Row words stay inside the addressed row
  a_row_addr: assert property (@(posedge mclk) disable iff (sys_rst) // R3
    flash_req && !flash_erase && q.op == `FSP_OP_ROW |-> flash_addr[23:7] == target[23:7])
    else $error("row word outside row");
  // Pair words sit at the odd word boundary and the word after it
  a_pair_addr: assert property (@(posedge mclk) disable iff (sys_rst) // R6
    flash_req && !flash_erase && q.op == `FSP_OP_PAIR |->
      flash_addr == {target[23:2], 2'b10} || flash_addr == {target[23:2], 2'b10} + 24'h2)
    else $error("pair address wrong");
  // One erase request per page, dropped right after its answer
  a_erase_once: assert property (@(posedge mclk) disable iff (sys_rst) // R2
    flash_req && flash_erase && flash_ack |=> !flash_req)
    else $error("erase repeated");
  // RAM is read at source plus three bytes per word
  a_ram_source: assert property (@(posedge mclk) disable iff (sys_rst) // R7
    ram_rd |-> ram_addr == src_of(source, q.idx))
    else $error("ram source address wrong");
  // Launch bit clears the cycle after completion
  a_launch_clear: assert property (@(posedge mclk) disable iff (sys_rst) // R5
    q.st == FSP_DONE |=> !q.launch && !cpu_stall)
    else $error("launch bit not cleared");
  // Key register reads back zero
  a_key_silent: assert property (@(posedge mclk) disable iff (sys_rst) // R10
    bus_go && avs_read && avs_address == `FSP_OFS_KEY |=> avs_readdata == 32'h0)
    else $error("key register readable");
  // Row fetch fills exactly the row before programming
  a_row_fill: assert property (@(posedge mclk) disable iff (sys_rst) // R1
    q.st == FSP_FCAP && q.idx == 7'(ROW_WORDS - 1) |=> q.st == FSP_PRD && q.idx == 7'd0)
    else $error("row fetch length wrong");
  // A read ends its wait one cycle after it starts
  a_read_answer: assert property (@(posedge mclk) disable iff (sys_rst) // R12
    avs_read && !q.ack |=> !avs_waitrequest)
    else $error("read not answered");
endmodule

// file: bench/fsp_far_model.sv
// Flash macro and data RAM standing beside the sequencer
`timescale 1ns/1ns
module fsp_far_model (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic flash_req,
  input wire logic ram_rd,
  input wire logic [23:0] ram_addr,
  input wire logic [3:0] ack_wait,
  output logic flash_ack,
  output logic [23:0] ram_rdata
);
  logic [3:0] cnt_q; // Cycles spent on the current flash request
  // Flash answers each request after ack_wait extra cycles, one-cycle pulse
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      flash_ack <= 1'b0;
      cnt_q <= 4'h0;
    end else begin
      flash_ack <= 1'b0;
      if (flash_req && !flash_ack) begin
        if (cnt_q >= ack_wait) begin
          flash_ack <= 1'b1;
          cnt_q <= 4'h0;
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end
    end
  end
  // RAM word is a scramble of its address, valid in the cycle of the read strobe
  always_comb begin
    if (ram_rd) begin
      ram_rdata = ram_addr ^ 24'h5a5a5a;
    end else begin
      ram_rdata = ~(ram_addr ^ 24'h5a5a5a); // Stale data never looks valid
    end
  end
endmodule

// file: bench/testbench.sv
// Self-checking bench for the flash self-programming sequencer
`timescale 1ns/1ns
`include "fsp_defines.svh"
module testbench;
  localparam int RW = 4; // Shortened row length
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, cpu_stall, flash_req, flash_erase, flash_ack, ram_rd;
  logic [23:0] flash_addr, flash_wdata, ram_addr, ram_rdata;
  logic [3:0] ack_wait = 4'h0; // Flash answer delay
  logic [48:0] seen_q[$]; // Flash requests as acknowledged
  logic [31:0] rd; // Last read data
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  // Clock of 4 ns period
  always #2 mclk = ~mclk;
  fsp_flash_seq #(.ROW_WORDS(RW)) dut (.mclk(mclk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cpu_stall(cpu_stall), .flash_req(flash_req), .flash_erase(flash_erase),
    .flash_addr(flash_addr), .flash_wdata(flash_wdata), .flash_ack(flash_ack),
    .ram_rd(ram_rd), .ram_addr(ram_addr), .ram_rdata(ram_rdata));
  fsp_far_model far (.mclk(mclk), .sys_rst(sys_rst), .flash_req(flash_req),
    .ram_rd(ram_rd), .ram_addr(ram_addr), .ack_wait(ack_wait),
    .flash_ack(flash_ack), .ram_rdata(ram_rdata));
  // Record every completed flash request
  always @(posedge mclk) begin
    if (flash_req === 1'b1 && flash_ack === 1'b1) begin
      seen_q.push_back({flash_erase, flash_addr, flash_wdata});
    end
  end
  // Cut a hang short
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One Avalon access; holds the request until waitrequest is low at an edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic wt;
    int n;
    n = 0;
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    // Sample waitrequest and read data at the rising edge itself
    do begin
      @(posedge mclk);
      wt = avs_waitrequest;
      n++;
    end while (wt !== 1'b0 && n < 2000);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (wt !== 1'b0) n_mismatch++;
    @(posedge mclk);
  endtask
  // Key pair, launching write, busy check, then wait for the end
  task automatic launch(input logic [7:0] k1, input logic [7:0] k2, input logic [3:0] op,
                        input logic go);
    int n;
    n = 0;
    bus(1'b1, `FSP_OFS_KEY, {24'h0, k1});
    bus(1'b1, `FSP_OFS_KEY, {24'h0, k2});
    bus(1'b1, `FSP_OFS_CTRL, 32'h0000c000 | {28'h0, op});
    repeat (2) @(posedge mclk);
    bus(1'b0, `FSP_OFS_CTRL, 32'h0);
    chk("launch bit", go, rd[15]);
    chk("cpu stall", go, cpu_stall);
    while (cpu_stall !== 1'b0 && n < 5000) begin
      @(posedge mclk);
      n++;
    end
    bus(1'b0, `FSP_OFS_CTRL, 32'h0);
    chk("launch cleared", 1'b0, rd[15]);
  endtask
  // Compare the oldest recorded flash request
  task automatic chk_flash(input logic er, input logic [23:0] a, input logic [23:0] d);
    logic [48:0] g;
    g = {1'b1, 48'h0};
    if (seen_q.size() > 0) g = seen_q.pop_front();
    chk("flash kind and address", {er, a}, g[48:24]);
    if (!er) chk("flash data", d, g[23:0]);
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    bus(1'b0, `FSP_OFS_CTRL, 32'h0);
    chk("control at reset", 32'h0, rd);
    bus(1'b1, `FSP_OFS_KEY, 32'h55);
    bus(1'b0, `FSP_OFS_KEY, 32'h0);
    chk("key read", 32'h0, rd);
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped read", 32'h0, rd);
    bus(1'b1, `FSP_OFS_ADRL, 32'h57ff);
    bus(1'b1, `FSP_OFS_ADRH, 32'h01);
    bus(1'b0, `FSP_OFS_ADRL, 32'h0);
    chk("target low", 32'h57ff, rd);
    bus(1'b0, `FSP_OFS_ADRH, 32'h0);
    chk("target high", 32'h01, rd);
    // Only the enabled byte lane of a write lands
    avs_byteenable <= 4'h1;
    bus(1'b1, `FSP_OFS_ADRL, 32'habcd);
    avs_byteenable <= 4'hf;
    bus(1'b0, `FSP_OFS_ADRL, 32'h0);
    chk("target low lane", 32'h57cd, rd);
    // Launches without a proper key sequence must do nothing
    bus(1'b1, `FSP_OFS_CTRL, 32'h0000c000 | {28'h0, `FSP_OP_PAGE});
    launch(8'haa, 8'h55, `FSP_OP_PAGE, 1'b0);
    launch(8'h55, 8'h5a, `FSP_OP_PAGE, 1'b0);
    // Keyed launch of an unknown operation flags an error and ends at once
    bus(1'b1, `FSP_OFS_KEY, 32'h55);
    bus(1'b1, `FSP_OFS_KEY, 32'haa);
    bus(1'b1, `FSP_OFS_CTRL, 32'h0000c004);
    bus(1'b0, `FSP_OFS_CTRL, 32'h0);
    chk("error flag", 32'h6004, rd);
    chk("cpu stall after error", 0, cpu_stall);
    chk("no flash traffic", 0, seen_q.size());
    // Page erase first, of the page at 0x015400, which the later programs do not touch
    ack_wait <= 4'h5;
    launch(`FSP_KEY_FIRST, `FSP_KEY_SECOND, `FSP_OP_PAGE, 1'b1);
    chk_flash(1'b1, 24'h015400, 24'h0);
    // Two-word program at a pair boundary
    bus(1'b1, `FSP_OFS_ADRL, 32'h2346);
    bus(1'b1, `FSP_OFS_DAT0, 32'h123456);
    bus(1'b1, `FSP_OFS_DAT1, 32'habcdef);
    ack_wait <= 4'h2;
    launch(`FSP_KEY_FIRST, `FSP_KEY_SECOND, `FSP_OP_PAIR, 1'b1);
    chk_flash(1'b0, 24'h012346, 24'h123456);
    chk_flash(1'b0, 24'h012348, 24'habcdef);
    // Row program fetched from RAM, prompt flash answers
    bus(1'b1, `FSP_OFS_ADRL, 32'h0123);
    bus(1'b1, `FSP_OFS_ADRH, 32'h00);
    bus(1'b1, `FSP_OFS_SRCL, 32'h0300);
    bus(1'b1, `FSP_OFS_SRCH, 32'h00);
    ack_wait <= 4'h0;
    launch(`FSP_KEY_FIRST, `FSP_KEY_SECOND, `FSP_OP_ROW, 1'b1);
    for (int i = 0; i < RW; i++) begin
      chk_flash(1'b0, 24'h000100 + 24'(2 * i), (24'h000300 + 24'(3 * i)) ^ 24'h5a5a5a);
    end
    chk("no extra flash traffic", 0, seen_q.size());
    complete_run();
  end
endmodule
